// [pwmdb_top.sv]
// pwm generator: timer, two compares, event actions, dead-band, outputs
// assumes FAULT arrives asynchronously from a pin; software on CLK
module pwmdb_top #(
   parameter int CW = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // pins
   input wire logic FAULT,
   output logic OUTPUT_PIN_ZERO,
   output logic OUTPUT_PIN_ONE,
   output logic ADC_TRIG
);
   import pwmdb_pkg::*;

   // -------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------
   logic [2:0] ctl_q, ctl_d;
   logic [1:0] en_q, en_d, inv_q, inv_d, flt_q, flt_d;
   logic [CW-1:0] load_sh_q, load_sh_d, cmpa_sh_q, cmpa_sh_d;
   logic [CW-1:0] cmpb_sh_q, cmpb_sh_d;
   logic [CW-1:0] load_q, load_d, cmpa_q, cmpa_d, cmpb_q, cmpb_d;
   logic pend_q, pend_d, armed_q, armed_d;
   logic [11:0] gena_q, gena_d, genb_q, genb_d;
   logic db_en_q, db_en_d;
   logic [11:0] rise_q, rise_d, fall_q, fall_d;
   logic [NUM_EV-1:0] trig_sel_q, trig_sel_d;
   logic [31:0] rdata_q, rdata_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic dir_q, dir_d;
   logic fault_s1_q, fault_s2_q;
   logic sig_a_q, sig_a_d, sig_b_q, sig_b_d;
   logic [11:0] dly_a_q, dly_a_d, dly_b_q, dly_b_d;
   logic db_a_q, db_a_d, db_b_q, db_b_d, in_prev_q, in_prev_d;
   logic pin0_q, pin0_d, pin1_q, pin1_d, trig_q, trig_d;
   logic ev_zero, ev_load, m_a, m_b;
   logic [NUM_EV-1:0] ev;
   logic run, updown, fault_now;
   logic [1:0] pre_out;

   assign run = ctl_q[CTL_RUN];
   assign updown = ctl_q[CTL_UPDOWN];

   always_comb begin
      ctl_d = ctl_q;
      en_d = en_q;
      inv_d = inv_q;
      flt_d = flt_q;
      load_sh_d = load_sh_q;
      cmpa_sh_d = cmpa_sh_q;
      cmpb_sh_d = cmpb_sh_q;
      gena_d = gena_q;
      genb_d = genb_q;
      db_en_d = db_en_q;
      rise_d = rise_q;
      fall_d = fall_q;
      trig_sel_d = trig_sel_q;
      pend_d = pend_q;
      armed_d = armed_q;
      rdata_d = RST_RDATA;
      // clear first so that a write in the apply cycle stays pending
      if (pend_q && ev_zero && (!ctl_q[CTL_SYNCMODE] || armed_q)) begin
         pend_d = 1'b0;
         armed_d = 1'b0;
      end
      if (WR) begin
         if (ADDR == OFF_CTL) begin
            ctl_d = WDATA[2:0];
         end else if (ADDR == OFF_SYNC) begin
            if (WDATA[0])
               armed_d = 1'b1;
         end else if (ADDR == OFF_ENABLE) begin
            en_d = WDATA[1:0];
         end else if (ADDR == OFF_INVERT) begin
            inv_d = WDATA[1:0];
         end else if (ADDR == OFF_FAULT) begin
            flt_d = WDATA[1:0];
         end else if (ADDR == OFF_LOAD) begin
            load_sh_d = WDATA[CW-1:0];
            pend_d = 1'b1;
         end else if (ADDR == OFF_CMPA) begin
            cmpa_sh_d = WDATA[CW-1:0];
            pend_d = 1'b1;
         end else if (ADDR == OFF_CMPB) begin
            cmpb_sh_d = WDATA[CW-1:0];
            pend_d = 1'b1;
         end else if (ADDR == OFF_GENA) begin
            gena_d = WDATA[11:0];
         end else if (ADDR == OFF_GENB) begin
            genb_d = WDATA[11:0];
         end else if (ADDR == OFF_DBCTL) begin
            db_en_d = WDATA[0];
         end else if (ADDR == OFF_DBRISE) begin
            rise_d = WDATA[11:0];
         end else if (ADDR == OFF_DBFALL) begin
            fall_d = WDATA[11:0];
         end else if (ADDR == OFF_TRIG) begin
            trig_sel_d = WDATA[NUM_EV-1:0];
         end
      end
      if (RD) begin
         if (ADDR == OFF_CTL) begin
            rdata_d = {29'h0, ctl_q};
         end else if (ADDR == OFF_ENABLE) begin
            rdata_d = {30'h0, en_q};
         end else if (ADDR == OFF_INVERT) begin
            rdata_d = {30'h0, inv_q};
         end else if (ADDR == OFF_FAULT) begin
            rdata_d = {30'h0, flt_q};
         end else if (ADDR == OFF_STATUS) begin
            rdata_d = {28'h0, fault_s2_q, pend_q, armed_q, dir_q};
         end else if (ADDR == OFF_LOAD) begin
            rdata_d = {16'h0, load_sh_q};
         end else if (ADDR == OFF_COUNT) begin
            rdata_d = {16'h0, cnt_q};
         end else if (ADDR == OFF_CMPA) begin
            rdata_d = {16'h0, cmpa_sh_q};
         end else if (ADDR == OFF_CMPB) begin
            rdata_d = {16'h0, cmpb_sh_q};
         end else if (ADDR == OFF_GENA) begin
            rdata_d = {20'h0, gena_q};
         end else if (ADDR == OFF_GENB) begin
            rdata_d = {20'h0, genb_q};
         end else if (ADDR == OFF_DBCTL) begin
            rdata_d = {31'h0, db_en_q};
         end else if (ADDR == OFF_DBRISE) begin
            rdata_d = {20'h0, rise_q};
         end else if (ADDR == OFF_DBFALL) begin
            rdata_d = {20'h0, fall_q};
         end else if (ADDR == OFF_TRIG) begin
            rdata_d = {26'h0, trig_sel_q};
         end
      end
   end

   // active values take the shadows when the pending update is applied
   always_comb begin
      load_d = load_q;
      cmpa_d = cmpa_q;
      cmpb_d = cmpb_q;
      if (pend_q && ev_zero && (!ctl_q[CTL_SYNCMODE] || armed_q)) begin
         load_d = load_sh_q;
         cmpa_d = cmpa_sh_q;
         cmpb_d = cmpb_sh_q;
      end
   end

   // -------------------------------------------------------------
   // timer and events
   // -------------------------------------------------------------
   assign ev_zero = run && (cnt_q == RST_WORD);
   assign ev_load = run && (cnt_q == load_q);
   // compare above load is never reached by the count
   assign m_a = run && (cnt_q == cmpa_q) && (cmpa_q <= load_q);
   assign m_b = run && (cnt_q == cmpb_q) && (cmpb_q <= load_q);

   always_comb begin
      ev = '0;
      ev[EV_ZERO] = ev_zero;
      ev[EV_LOAD] = ev_load;
      // up matches exist only in up/down mode
      ev[EV_AUP] = m_a && dir_q && updown;
      ev[EV_ADN] = m_a && !dir_q;
      ev[EV_BUP] = m_b && dir_q && updown;
      ev[EV_BDN] = m_b && !dir_q;
   end

   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (!run) begin
         cnt_d = cnt_q;
      end else if (!updown) begin
         dir_d = 1'b0;
         if (cnt_q == RST_WORD)
            cnt_d = load_d;
         else
            cnt_d = cnt_q - 1'b1;
      end else begin
         if (dir_q && cnt_q >= load_q) begin
            dir_d = 1'b0;
            cnt_d = cnt_q - 1'b1;
         end else if (!dir_q && cnt_q == RST_WORD) begin
            dir_d = 1'b1;
            cnt_d = cnt_q + 1'b1;
         end else if (dir_q) begin
            cnt_d = cnt_q + 1'b1;
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
         if (load_q == RST_WORD)
            cnt_d = RST_WORD;
      end
   end

   // -------------------------------------------------------------
   // signal generator
   // -------------------------------------------------------------
   function automatic logic apply_act(input logic cur,
                                      input logic [1:0] code);
      logic r;
      r = cur;
      case (pwmdb_act_t'(code))
         PWMDB_ACT_NONE: r = cur;
         PWMDB_ACT_TOGGLE: r = !cur;
         PWMDB_ACT_LOW: r = 1'b0;
         PWMDB_ACT_HIGH: r = 1'b1;
         default: r = cur;
      endcase
      return r;
   endfunction : apply_act

   // zero/load win over matches; A matches drive only signal A, B matches only signal B
   function automatic logic gen_next(input logic cur,
                                     input logic [11:0] acts,
                                     input logic [NUM_EV-1:0] e,
                                     input logic own_b);
      logic r;
      r = cur;
      if (e[EV_ZERO])
         r = apply_act(cur, acts[2*EV_ZERO +: 2]);
      else if (e[EV_LOAD])
         r = apply_act(cur, acts[2*EV_LOAD +: 2]);
      else if (!own_b && e[EV_AUP])
         r = apply_act(cur, acts[2*EV_AUP +: 2]);
      else if (!own_b && e[EV_ADN])
         r = apply_act(cur, acts[2*EV_ADN +: 2]);
      else if (own_b && e[EV_BUP])
         r = apply_act(cur, acts[2*EV_BUP +: 2]);
      else if (own_b && e[EV_BDN])
         r = apply_act(cur, acts[2*EV_BDN +: 2]);
      return r;
   endfunction : gen_next

   assign sig_a_d = gen_next(sig_a_q, gena_q, ev, 1'b0);
   assign sig_b_d = gen_next(sig_b_q, genb_q, ev, 1'b1);

   // -------------------------------------------------------------
   // dead-band
   // -------------------------------------------------------------
   always_comb begin
      in_prev_d = sig_a_q;
      db_a_d = db_a_q;
      db_b_d = db_b_q;
      dly_a_d = dly_a_q;
      dly_b_d = dly_b_q;
      if (sig_a_q) begin
         // drop the low side at once, then wait before the high side
         db_b_d = 1'b0;
         dly_b_d = '0;
         if (!in_prev_q)
            dly_a_d = '0;
         else if (dly_a_q != 12'hfff)
            dly_a_d = dly_a_q + 1'b1;
         if (in_prev_q && dly_a_q >= rise_q)
            db_a_d = 1'b1;
      end else begin
         db_a_d = 1'b0;
         dly_a_d = '0;
         if (in_prev_q)
            dly_b_d = '0;
         else if (dly_b_q != 12'hfff)
            dly_b_d = dly_b_q + 1'b1;
         if (!in_prev_q && dly_b_q >= fall_q)
            db_b_d = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // output control
   // -------------------------------------------------------------
   assign fault_now = fault_s2_q;
   assign pre_out = db_en_q ? {db_b_q, db_a_q}
                            : {sig_b_q, sig_a_q};
   // inactive level is the inverted low when inversion is set
   assign pin0_d = (en_q[0] && !(flt_q[0] && fault_now) && pre_out[0])
                   ^ inv_q[0];
   assign pin1_d = (en_q[1] && !(flt_q[1] && fault_now) && pre_out[1])
                   ^ inv_q[1];
   assign trig_d = |(ev & trig_sel_q);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctl_q <= 3'h0;
         en_q <= 2'h0;
         inv_q <= 2'h0;
         flt_q <= 2'h0;
         load_sh_q <= RST_WORD;
         cmpa_sh_q <= RST_WORD;
         cmpb_sh_q <= RST_WORD;
         load_q <= RST_WORD;
         cmpa_q <= RST_WORD;
         cmpb_q <= RST_WORD;
         pend_q <= 1'b0;
         armed_q <= 1'b0;
         gena_q <= 12'h000;
         genb_q <= 12'h000;
         db_en_q <= 1'b0;
         rise_q <= 12'h000;
         fall_q <= 12'h000;
         trig_sel_q <= 6'h00;
         rdata_q <= RST_RDATA;
         cnt_q <= RST_WORD;
         dir_q <= 1'b0;
         fault_s1_q <= 1'b0;
         fault_s2_q <= 1'b0;
         sig_a_q <= 1'b0;
         sig_b_q <= 1'b0;
         dly_a_q <= 12'h000;
         dly_b_q <= 12'h000;
         db_a_q <= 1'b0;
         db_b_q <= 1'b0;
         in_prev_q <= 1'b0;
         pin0_q <= 1'b0;
         pin1_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         en_q <= en_d;
         inv_q <= inv_d;
         flt_q <= flt_d;
         load_sh_q <= load_sh_d;
         cmpa_sh_q <= cmpa_sh_d;
         cmpb_sh_q <= cmpb_sh_d;
         load_q <= load_d;
         cmpa_q <= cmpa_d;
         cmpb_q <= cmpb_d;
         pend_q <= pend_d;
         armed_q <= armed_d;
         gena_q <= gena_d;
         genb_q <= genb_d;
         db_en_q <= db_en_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         trig_sel_q <= trig_sel_d;
         rdata_q <= rdata_d;
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         fault_s1_q <= FAULT;
         fault_s2_q <= fault_s1_q;
         sig_a_q <= sig_a_d;
         sig_b_q <= sig_b_d;
         dly_a_q <= dly_a_d;
         dly_b_q <= dly_b_d;
         db_a_q <= db_a_d;
         db_b_q <= db_b_d;
         in_prev_q <= in_prev_d;
         pin0_q <= pin0_d;
         pin1_q <= pin1_d;
         trig_q <= trig_d;
      end
   end

   assign RDATA = rdata_q;
   assign OUTPUT_PIN_ZERO = pin0_q;
   assign OUTPUT_PIN_ONE = pin1_q;
   assign ADC_TRIG = trig_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_db_exclusive: assert property (!(db_a_q && db_b_q))
      else $error("dead-band outputs both high");
   a_down_dir_low: assert property (run && !updown |=> !dir_q)
      else $error("direction high in down mode");
   a_down_reload: assert property (
      run && !updown && cnt_q == 16'h0000 && !(pend_q) |=> cnt_q == load_q)
      else $error("no reload after zero");
   a_down_decr: assert property (
      run && !updown && cnt_q != 16'h0000 |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("count did not decrement");
   a_nomatch_above: assert property (cmpa_q > load_q |-> !m_a)
      else $error("match above load");
   a_zero_masks: assert property (
      ev_zero |=> sig_a_q == apply_act($past(sig_a_q), $past(gena_q[1:0])))
      else $error("zero action not applied");
   a_fault_force: assert property (
      fault_s2_q && flt_q[0] |=> pin0_q == $past(inv_q[0]))
      else $error("fault did not force output");
   a_disable_pin: assert property (!en_q[1] |=> pin1_q == $past(inv_q[1]))
      else $error("disabled pin not inactive");
   a_db_bypass: assert property (
      !db_en_q && en_q[0] && !flt_q[0] && !inv_q[0] |=> pin0_q == $past(sig_a_q))
      else $error("bypass does not pass signal");
   a_trig_event: assert property (trig_d |=> ADC_TRIG)
      else $error("trigger lost");

   c_updown: cover property (run && updown && dir_q ##1 !dir_q);
   c_db_both_low: cover property (db_en_q && !db_a_q && !db_b_q);
   c_fault: cover property (fault_s2_q && flt_q != 2'b00);
   c_sync_apply: cover property (armed_q && pend_q && ev_zero);
endmodule : pwmdb_top

// [pwmdb_pkg.sv]
// constants shared by the pwm generator with dead-band
// assumes a single 20 MHz module clock and a plain register port
package pwmdb_pkg;
   localparam int CLK_HZ = 20000000;
   // register offsets
   localparam logic [7:0] OFF_CTL = 8'h00;
   localparam logic [7:0] OFF_SYNC = 8'h04;
   localparam logic [7:0] OFF_ENABLE = 8'h08;
   localparam logic [7:0] OFF_INVERT = 8'h0c;
   localparam logic [7:0] OFF_FAULT = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_LOAD = 8'h18;
   localparam logic [7:0] OFF_COUNT = 8'h1c;
   localparam logic [7:0] OFF_CMPA = 8'h20;
   localparam logic [7:0] OFF_CMPB = 8'h24;
   localparam logic [7:0] OFF_GENA = 8'h28;
   localparam logic [7:0] OFF_GENB = 8'h2c;
   localparam logic [7:0] OFF_DBCTL = 8'h30;
   localparam logic [7:0] OFF_DBRISE = 8'h34;
   localparam logic [7:0] OFF_DBFALL = 8'h38;
   localparam logic [7:0] OFF_TRIG = 8'h3c;
   // control register fields
   localparam int CTL_RUN = 0;
   localparam int CTL_UPDOWN = 1;
   localparam int CTL_SYNCMODE = 2;
   // event bit positions (trigger select, action field index)
   localparam int EV_ZERO = 0;
   localparam int EV_LOAD = 1;
   localparam int EV_AUP = 2;
   localparam int EV_ADN = 3;
   localparam int EV_BUP = 4;
   localparam int EV_BDN = 5;
   localparam int NUM_EV = 6;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   // two-bit action codes
   typedef enum logic [1:0] {
      PWMDB_ACT_NONE = 2'b00,
      PWMDB_ACT_TOGGLE = 2'b01,
      PWMDB_ACT_LOW = 2'b10,
      PWMDB_ACT_HIGH = 2'b11
   } pwmdb_act_t;
endpackage : pwmdb_pkg

// [pwmdb_bridge.sv]
// half-bridge power stage model fed by the two output pins
// assumes pin zero drives the high-side gate, pin one the low side
module pwmdb_bridge (
   // clock
   input wire logic clk,
   // restart of the count
   input wire logic clr,
   // gate drives, active high
   input wire logic gate_hi,
   input wire logic gate_lo,
   // cycles seen with both gates on
   output int shoot_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   // both switches on would short the rail
   always @(posedge clk) begin
      if (clr)
         shoot_cnt <= 0;
      else if (gate_hi === 1'b1 && gate_lo === 1'b1)
         shoot_cnt <= shoot_cnt + 1;
   end
endmodule : pwmdb_bridge

// [tb_pwmdb_top.sv]
// self-checking bench for the pwm generator with dead-band
// assumes pwmdb_pkg and the bridge model are compiled before it
module tb_pwmdb_top;
   import pwmdb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic FAULT = 1'b0;
   logic clr = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0000_0000;
   logic [31:0] RDATA, d, e;
   logic [15:0] c;
   logic OUTPUT_PIN_ZERO, OUTPUT_PIN_ONE, ADC_TRIG;
   int failures = 0;
   int check_count = 0;
   int shoot, n0, n1, nt, l, ca, cb, p, r, f;
   bit up, m, fl;
   bit [1:0] en, inv, fs;
   always #25 CLK = ~CLK;
   pwmdb_top u_pwmdb_top (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FAULT(FAULT),
      .OUTPUT_PIN_ZERO(OUTPUT_PIN_ZERO), .OUTPUT_PIN_ONE(OUTPUT_PIN_ONE),
      .ADC_TRIG(ADC_TRIG));
   pwmdb_bridge u_pwmdb_bridge (.clk(CLK), .clr(clr),
      .gate_hi(OUTPUT_PIN_ZERO), .gate_lo(OUTPUT_PIN_ONE),
      .shoot_cnt(shoot));
   // ---------------------------------------------
   // tasks and expectations
   // ---------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] x,
                      input string msg);
      check_count++;
      if (s !== x) begin
         failures++;
         $display("MISMATCH t=%0t %s: %h not %h", $time, msg, s, x);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      v = RDATA;
   endtask : rd
   task automatic rst;
      @(posedge CLK);
      RST_N <= 1'b0;
      FAULT <= 1'b0;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
   endtask : rst
   // counts pin and trigger high cycles over a window
   task automatic meas(input int w);
      n0 = 0;
      n1 = 0;
      nt = 0;
      repeat (w) begin
         @(negedge CLK);
         n0 += int'(OUTPUT_PIN_ZERO === 1'b1);
         n1 += int'(OUTPUT_PIN_ONE === 1'b1);
         nt += int'(ADC_TRIG === 1'b1);
      end
   endtask : meas
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   function automatic void step(inout logic [15:0] v, inout bit u,
                                input bit md, input int lv);
      if (!md)
         v = (v == 16'h0000) ? 16'(lv) : v - 16'h0001;
      else begin
         if (v >= lv)
            u = 1'b0;
         else if (v == 16'h0000)
            u = 1'b1;
         v = u ? v + 16'h0001 : v - 16'h0001;
      end
   endfunction : step
   // high cycles per period: zero-high/a-low or up-high/down-low
   function automatic int hper(bit md, int lv, int c0);
      if (c0 == 0 || c0 >= lv)
         return md ? 0 : lv + 1;
      return md ? 2 * (lv - c0) : lv - c0 + 1;
   endfunction : hper
   // disabled or faulted pins rest at the inverted idle level
   function automatic int pexp(bit e1, bit i1, int hp, int w);
      if (!e1)
         return i1 ? w : 0;
      return i1 ? w - hp : hp;
   endfunction : pexp
   initial begin
      repeat (60000) @(posedge CLK);
      failures++;
      stop_test;
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      void'($urandom(32'h07eed529));
      rst;
      for (int a = 0; a <= 'h40; a += 4) begin
         rd(8'(a), d);
         chk(d, 32'h0, "reset or unmapped read");
      end
      wr(OFF_LOAD, 32'h0000_ffff);
      wr(OFF_COUNT, 32'h0000_0005);
      wr(8'h40, 32'h0000_0007);
      wr(OFF_SYNC, 32'h0000_0001);
      rd(OFF_LOAD, d);
      chk(d, 32'h0000_ffff, "load width");
      rd(OFF_COUNT, d);
      chk(d, 32'h0, "count read only");
      rd(8'h40, d);
      chk(d, 32'h0, "unmapped write");
      $display("test registers done");
      for (int k = 0; k < 2; k++) begin
         m = k[0];
         l = $urandom_range(12, 3);
         rst;
         wr(OFF_LOAD, 32'(l));
         wr(OFF_CTL, {30'h0, m, 1'b1});
         repeat (3 * l + 6) @(posedge CLK);
         rd(OFF_COUNT, d);
         rd(OFF_COUNT, e);
         up = 1'b0;
         c = d[15:0];
         step(c, up, m, l);
         step(c, up, m, l);
         if (c !== e[15:0]) begin
            up = 1'b1;
            c = d[15:0];
            step(c, up, m, l);
            step(c, up, m, l);
         end
         repeat (20) begin
            step(c, up, m, l);
            step(c, up, m, l);
            rd(OFF_COUNT, e);
            chk(e, {16'h0000, c}, "count sequence");
         end
         $display("test counter mode %0d done", k);
      end
      for (int i = 0; i < 10; i++) begin
         m = i[0];
         l = $urandom_range(30, 4);
         ca = (i < 4) ? i / 2 * l : $urandom_range(l + 1, 0);
         cb = (i < 4) ? l + 1 : $urandom_range(l + 1, 0);
         {en, inv, fs, fl} = 7'($urandom);
         p = m ? 2 * l : l + 1;
         rst;
         wr(OFF_LOAD, 32'(l));
         wr(OFF_CMPA, 32'(ca));
         wr(OFF_CMPB, 32'(cb));
         wr(OFF_GENA, m ? 32'h0b0 : 32'h083);
         wr(OFF_GENB, m ? 32'hb00 : 32'h803);
         wr(OFF_ENABLE, {30'h0, en});
         wr(OFF_INVERT, {30'h0, inv});
         wr(OFF_FAULT, {30'h0, fs});
         wr(OFF_TRIG, 32'h1 << EV_ZERO);
         wr(OFF_CTL, {30'h0, m, 1'b1});
         FAULT <= fl;
         repeat (2 * p + 6) @(posedge CLK);
         meas(4 * p);
         chk(n0, pexp(en[0] & ~(fl & fs[0]), inv[0], 4 * hper(m, l, ca),
             4 * p), "pin zero");
         chk(n1, pexp(en[1] & ~(fl & fs[1]), inv[1], 4 * hper(m, l, cb),
             4 * p), "pin one");
         chk(nt, 4, "adc trigger");
         $display("test random %0d done", i);
      end
      r = $urandom_range(8, 1);
      f = $urandom_range(8, 1);
      rst;
      wr(OFF_LOAD, 32'd40);
      wr(OFF_CMPA, 32'd20);
      wr(OFF_GENA, 32'h083);
      wr(OFF_DBCTL, 32'h1);
      wr(OFF_DBRISE, 32'(r));
      wr(OFF_DBFALL, 32'(f));
      wr(OFF_ENABLE, 32'h3);
      wr(OFF_CTL, 32'h1);
      repeat (100) @(posedge CLK);
      clr <= 1'b1;
      @(posedge CLK);
      clr <= 1'b0;
      meas(164);
      chk(shoot, 0, "both outputs high");
      chk(n0 inside {[76 - 4 * r : 84 - 4 * r]}, 1, "rise delay");
      chk(n1 inside {[72 - 4 * f : 80 - 4 * f]}, 1, "fall delay");
      $display("test dead-band done");
      rst;
      wr(OFF_LOAD, 32'd9);
      wr(OFF_CMPA, 32'd4);
      wr(OFF_GENA, 32'h083);
      wr(OFF_ENABLE, 32'h1);
      wr(OFF_SYNC, 32'h1);
      wr(OFF_CTL, 32'h5);
      repeat (30) @(posedge CLK);
      meas(40);
      chk(n0, 24, "sync first values");
      wr(OFF_CMPA, 32'd2);
      repeat (30) @(posedge CLK);
      meas(40);
      chk(n0, 24, "held until update");
      wr(OFF_SYNC, 32'h1);
      repeat (30) @(posedge CLK);
      meas(40);
      chk(n0, 32, "after update");
      $display("test sync update done");
      stop_test;
   end
endmodule : tb_pwmdb_top
